// [logic/seq_pkg.sv]
/*
  Constants shared by the programmable Mealy sequencer: array sizes,
  the layout of one stored transition-term configuration word and
  the reset values of the registers and the configuration store.
  Assumes nothing of its surroundings; imported by every design file.
*/
`default_nettype none

package seq_pkg;

  // array sizes
  localparam int N_EXT      = 16;                 // external inputs
  localparam int N_STATE    = 6;                  // state register bits
  localparam int N_OUT      = 8;                  // output register bits
  localparam int N_VAR      = N_EXT + N_STATE;    // 22 true/complement buffers
  localparam int N_TERM     = 48;                 // transition-term AND gates
  localparam int N_FF       = N_STATE + N_OUT;    // 14 set/reset flip-flops
  localparam int AND_INPUTS = 2 * N_VAR + 1;      // 45 inputs per AND gate

  // one configuration word per transition term; a 1 means link intact
  localparam int AND_T_LSB  = 0;                  // true links, N_VAR bits
  localparam int AND_C_LSB  = AND_T_LSB + N_VAR;  // complement links, N_VAR bits
  localparam int C_GEN_BIT  = AND_C_LSB + N_VAR;  // term feeds the complement gate
  localparam int C_PROP_BIT = C_GEN_BIT + 1;      // term takes the complement gate
  localparam int SET_LSB    = C_PROP_BIT + 1;     // set links, N_FF bits
  localparam int RST_LSB    = SET_LSB + N_FF;     // reset links, N_FF bits
  localparam int CFG_W      = RST_LSB + N_FF;     // 74 bits

  // term index of the load port
  localparam int                    TERM_IDX_W = 6;
  localparam logic [TERM_IDX_W-1:0] TERM_COUNT = 6'h30;

  // reset values: virgin store has every link intact, option is preset
  localparam logic [CFG_W-1:0]   CFG_WORD_RST    = {CFG_W{1'b1}};
  localparam logic               PRESET_MODE_RST = 1'b1;
  localparam logic [N_STATE-1:0] STATE_RST       = {N_STATE{1'b1}};
  localparam logic [N_OUT-1:0]   OUT_RST         = {N_OUT{1'b1}};
  localparam logic               OE_RST          = 1'b1;

endpackage

`default_nettype wire

// [logic/transition_array.sv]
/*
  AND plane with its complement gate: forty-eight transition terms
  built from the true/complement buffered variables, plus the single
  complement-array OR gate fed back into the dedicated AND inputs.
  Purely combinational; assumes stable link patterns while used.
*/
`timescale 1ns/1ps
`default_nettype none

module transition_array
  import seq_pkg::*;
#(
  parameter int NV = N_VAR,
  parameter int NT = N_TERM
) (
  input  wire logic [NV-1:0]         vars_i,
  input  wire logic [NT-1:0][NV-1:0] link_true_i,
  input  wire logic [NT-1:0][NV-1:0] link_comp_i,
  input  wire logic [NT-1:0]         gen_i,
  input  wire logic [NT-1:0]         prop_i,
  output logic      [NT-1:0]         term_o,
  output logic                       comp_gate_o
);

  logic [NT-1:0] base;
  logic [NT-1:0] gen_hit;
  logic          comp_n;

  ////////////////////////////////////////////////////////////////////////////
  // direct AND part of each term
  genvar n;
  generate
    for (n = 0; n < NT; n++) begin : g_term
      // intact true link needs var=1, intact complement link needs var=0
      assign base[n] = &((~link_true_i[n] | vars_i)
                         & (~link_comp_i[n] | ~vars_i));
      // a term with both complement links kept cannot feed the gate: no loop
      assign gen_hit[n] = base[n] & gen_i[n] & ~prop_i[n];
      // dedicated 45th input takes the inverted complement gate
      assign term_o[n] = base[n] & (~prop_i[n] | comp_n);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // complement gate: only terms true in the present state can reach it
  assign comp_gate_o = |gen_hit;
  assign comp_n      = ~comp_gate_o;

endmodule

`default_nettype wire

// [logic/or_plane.sv]
/*
  OR plane: one set gate and one reset gate for each register stage,
  each able to select any of the transition terms.
  Purely combinational; the caller resolves set/reset into next state.
*/
`timescale 1ns/1ps
`default_nettype none

module or_plane
  import seq_pkg::*;
#(
  parameter int NT = N_TERM,
  parameter int NF = N_FF
) (
  input  wire logic [NT-1:0]         term_i,
  input  wire logic [NT-1:0][NF-1:0] set_link_i,
  input  wire logic [NT-1:0][NF-1:0] rst_link_i,
  output logic      [NF-1:0]         set_o,
  output logic      [NF-1:0]         rst_o
);

  logic [NF-1:0][NT-1:0] set_col;
  logic [NF-1:0][NT-1:0] rst_col;

  ////////////////////////////////////////////////////////////////////////////
  // transpose the per-term links into per-gate columns and OR them
  genvar f, n;
  generate
    for (f = 0; f < NF; f++) begin : g_gate
      for (n = 0; n < NT; n++) begin : g_link
        assign set_col[f][n] = set_link_i[n][f];
        assign rst_col[f][n] = rst_link_i[n][f];
      end
      assign set_o[f] = |(term_i & set_col[f]);
      assign rst_o[f] = |(term_i & rst_col[f]);
    end
  endgenerate

endmodule

`default_nettype wire

// [logic/mealy_sequencer.sv]
/*
  Top of the programmable Mealy sequencer: configuration store, state
  and output registers, preset/output-enable option and checks.
  Assumes all inputs synchronous to clk_i, and that the surrounding
  logic loads the link pattern before it relies on the registers.
*/
// What this block does
// - Each committed register change comes from present state and present inputs.
// - A true term loads next state and output changes at the clock edge.
// - Sixteen inputs plus six state bits feed twenty-two true/complement buffers.
// - Each variable joins a term as true, complement, or don't care.
// - Forty-eight AND gates, forty-four buffer inputs plus one complement input.
// - A term with both links of any variable kept is always false.
// - Fourteen set/reset gate pairs, each selecting any of the forty-eight terms.
// - Output register is separate and holds when no change is programmed.
// - One complement gate ORs chosen terms, inverted result feeds chosen terms.
// - Complement jump is true only when all linked direct terms are false.
// - Only terms of the present state influence the complement gate.
// - Unloaded store keeps every link, all terms inactive, option is preset.
// - At power-up all state and output flip-flops are one.
// - Preset mode: high pin forces ones asynchronously; else low pin enables outputs.
// - Both registers change on the rising clock edge, or at once when preset acts.
`timescale 1ns/1ps
`default_nettype none

module mealy_sequencer
  import seq_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [N_EXT-1:0]      ext_input_i,
  input  wire logic                  preset_or_output_enable_pin_i,
  input  wire logic                  cfg_we_i,
  input  wire logic [TERM_IDX_W-1:0] cfg_term_i,
  input  wire logic [CFG_W-1:0]      cfg_word_i,
  input  wire logic                  cfg_opt_we_i,
  input  wire logic                  cfg_opt_preset_i,
  output logic      [N_OUT-1:0]      output_bit_o,
  output logic                       output_bit_oe_o,
  output logic      [N_STATE-1:0]    present_state_bit_o
);

  logic [CFG_W-1:0]             cfg_mem_q [N_TERM];
  logic                         preset_mode_q;
  logic                         cfg_touched_q;
  logic [N_STATE-1:0]           state_q;
  logic [N_STATE-1:0]           state_d;
  logic [N_OUT-1:0]             out_q;
  logic [N_OUT-1:0]             out_d;
  logic                         oe_q;
  logic [N_TERM-1:0][N_VAR-1:0] and_true;
  logic [N_TERM-1:0][N_VAR-1:0] and_comp;
  logic [N_TERM-1:0][N_FF-1:0]  set_link;
  logic [N_TERM-1:0][N_FF-1:0]  rst_link;
  logic [N_TERM-1:0]            gen_vec;
  logic [N_TERM-1:0]            prop_vec;
  logic [N_TERM-1:0]            term_vec;
  logic [N_TERM-1:0]            conflict;
  logic [N_VAR-1:0]             vars;
  logic [N_FF-1:0]              set_vec;
  logic [N_FF-1:0]              rst_vec;
  logic [N_FF-1:0]              set_only;
  logic [N_FF-1:0]              rst_only;
  logic [N_FF-1:0]              ff_cur;
  logic [N_FF-1:0]              ff_d;
  logic                         comp_gate;
  logic                         preset_act;
  logic                         cfg_busy;
  logic                         term_any;

  ////////////////////////////////////////////////////////////////////////////
  // configuration store

  // virgin store keeps every link; index 48..63 is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_TERM; i++) begin
        cfg_mem_q[i] <= CFG_WORD_RST;
      end
    end else if (cfg_we_i && (cfg_term_i < TERM_COUNT)) begin
      cfg_mem_q[cfg_term_i] <= cfg_word_i;
    end
  end

  // option bit defaults to preset, output enable only when loaded so
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preset_mode_q <= PRESET_MODE_RST;
    end else if (cfg_opt_we_i) begin
      preset_mode_q <= cfg_opt_preset_i;
    end
  end

  // remembers whether any term word was ever loaded since reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_touched_q <= 1'b0;
    end else if (cfg_we_i && (cfg_term_i < TERM_COUNT)) begin
      cfg_touched_q <= 1'b1;
    end
  end

  // unpack each stored word into the array link fields
  genvar n;
  generate
    for (n = 0; n < N_TERM; n++) begin : g_unpack
      assign and_true[n] = cfg_mem_q[n][AND_T_LSB +: N_VAR];
      assign and_comp[n] = cfg_mem_q[n][AND_C_LSB +: N_VAR];
      assign gen_vec[n]  = cfg_mem_q[n][C_GEN_BIT];
      assign prop_vec[n] = cfg_mem_q[n][C_PROP_BIT];
      assign set_link[n] = cfg_mem_q[n][SET_LSB +: N_FF];
      assign rst_link[n] = cfg_mem_q[n][RST_LSB +: N_FF];
      assign conflict[n] = |(and_true[n] & and_comp[n]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // logic arrays

  // buffered variables: external inputs above the state feedback
  assign vars = {ext_input_i, state_q};

  transition_array #(
    .NV (N_VAR),
    .NT (N_TERM)
  ) u_and (
    .vars_i      (vars),
    .link_true_i (and_true),
    .link_comp_i (and_comp),
    .gen_i       (gen_vec),
    .prop_i      (prop_vec),
    .term_o      (term_vec),
    .comp_gate_o (comp_gate)
  );

  or_plane #(
    .NT (N_TERM),
    .NF (N_FF)
  ) u_or (
    .term_i     (term_vec),
    .set_link_i (set_link),
    .rst_link_i (rst_link),
    .set_o      (set_vec),
    .rst_o      (rst_vec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state of the fourteen set/reset stages

  // set and reset together is not a legal pattern; the stage then holds
  assign set_only = set_vec & ~rst_vec;
  assign rst_only = rst_vec & ~set_vec;
  assign ff_cur   = {out_q, state_q};
  assign ff_d     = (ff_cur | set_only) & ~rst_only;
  assign state_d  = ff_d[N_STATE-1:0];
  assign out_d    = ff_d[N_FF-1:N_STATE];
  assign term_any = |term_vec;

  // loading the store stalls the registers so no half-written pattern acts
  assign cfg_busy   = cfg_we_i | cfg_opt_we_i;
  assign preset_act = preset_or_output_enable_pin_i & preset_mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // state register; preset is an async set that overrides the clock
  always_ff @(posedge clk_i or negedge rst_n_i or posedge preset_act) begin
    if (!rst_n_i) begin
      state_q <= STATE_RST;
    end else if (preset_act) begin
      state_q <= STATE_RST;
    end else if (!cfg_busy) begin
      state_q <= state_d;
    end
  end

  // output register, separate from state; unprogrammed bits hold
  always_ff @(posedge clk_i or negedge rst_n_i or posedge preset_act) begin
    if (!rst_n_i) begin
      out_q <= OUT_RST;
    end else if (preset_act) begin
      out_q <= OUT_RST;
    end else if (!cfg_busy) begin
      out_q <= out_d;
    end
  end

  // output enable lags the pin by one cycle so the port comes from a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= OE_RST;
    end else begin
      oe_q <= preset_mode_q | ~preset_or_output_enable_pin_i;
    end
  end

  // ports come straight from the register flops, no logic in between
  assign output_bit_o        = out_q;
  assign output_bit_oe_o     = oe_q;
  assign present_state_bit_o = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // a cycle with nothing to act and no preset around it
  sequence s_quiet;
    !term_any && !cfg_busy && !preset_act;
  endsequence

  sequence s_calm_step;
    s_quiet ##1 !preset_act;
  endsequence

  sequence s_run_step;
    (!cfg_busy && !preset_act) ##1 !preset_act;
  endsequence

  // the first sampled edge once reset has gone away
  sequence s_reset_exit;
    $rose(rst_n_i);
  endsequence

  // two edges in a row with the preset pin active
  sequence s_preset_held;
    preset_act ##1 preset_act;
  endsequence

  AST_HOLD_QUIET: assert property (s_calm_step |-> $stable(out_q) && $stable(state_q))
    else $error("registers moved with no active term");

  AST_MEALY_CAUSE: assert property (
    (!$stable(ff_cur) && !preset_act && !$past(preset_act))
      |-> $past(term_any) && !$past(cfg_busy))
    else $error("register change without a true term");

  AST_SET_LOAD: assert property (
    s_run_step |-> ((ff_cur & $past(set_only)) == $past(set_only)))
    else $error("selected set did not load a one");

  AST_RST_LOAD: assert property (
    s_run_step |-> ((~ff_cur & $past(rst_only)) == $past(rst_only)))
    else $error("selected reset did not load a zero");

  AST_CONFLICT_FALSE: assert property ((term_vec & conflict) == '0)
    else $error("term with a kept link pair went true");

  AST_COMP_JUMP: assert property (
    (|(term_vec & prop_vec & ~gen_vec)) |-> !(|(term_vec & gen_vec & ~prop_vec)))
    else $error("complement jump true with a linked direct term true");

  AST_VIRGIN_INERT: assert property (!cfg_touched_q |-> !term_any && !comp_gate)
    else $error("term active before any pattern was loaded");

  AST_PRESET_ONES: assert property (
    preset_act |-> (state_q == STATE_RST) && (out_q == OUT_RST))
    else $error("preset did not hold all register bits high");

  AST_CFG_FREEZE: assert property (
    (cfg_busy && !preset_act) ##1 !preset_act |-> $stable(ff_cur))
    else $error("registers moved during a store load");

  AST_OE_FOLLOW: assert property (
    !$past(preset_mode_q) |-> (output_bit_oe_o == !$past(preset_or_output_enable_pin_i)))
    else $error("output enable did not follow the low-active pin");

  AST_OE_PRESET_MODE: assert property ($past(preset_mode_q) |-> output_bit_oe_o)
    else $error("outputs disabled while in preset mode");

  // power-on values stand at the first edge after reset, store still inert
  AST_POWER_ONES: assert property (
    s_reset_exit |-> (ff_cur == {OUT_RST, STATE_RST}) && output_bit_oe_o)
    else $error("registers not all ones after reset");

  AST_OPTION_DEFAULT: assert property (
    s_reset_exit |-> preset_mode_q && !term_any)
    else $error("option or terms not in their virgin setting after reset");

  // the gate sees exactly the true generate terms, so other states stay out
  AST_COMP_SOURCES: assert property (
    comp_gate == |(term_vec & gen_vec & ~prop_vec))
    else $error("complement gate driven by a term that is not true");

  // a propagate term may only fire while the gate is quiet
  AST_PROP_QUIET: assert property (
    (|(term_vec & prop_vec & ~gen_vec)) |-> !comp_gate)
    else $error("complement jump fired with the gate active");

  // an illegal set/reset pair leaves its stage where it was
  AST_PAIR_HOLD: assert property (
    s_run_step |-> (((ff_cur ^ $past(ff_cur)) & $past(set_vec) & $past(rst_vec)) == '0))
    else $error("stage moved under a set/reset pair");

  // with the pin held high in preset mode no clock edge may move a register
  AST_PRESET_INHIBIT: assert property (s_preset_held |-> $stable(ff_cur))
    else $error("register clocked while preset was held");

  // outputs are released only by a high enable pin in enable mode
  AST_OE_DISABLE_CAUSE: assert property (
    !output_bit_oe_o |-> !$past(preset_mode_q) && $past(preset_or_output_enable_pin_i))
    else $error("outputs released without the enable pin high in enable mode");

endmodule

`default_nettype wire

// [dv/sys_logic_model.sv]
/*
  System logic around the sequencer: drives the external inputs and
  feeds chosen output pins back onto inputs 8..15 to widen the state.
  Assumes pulled-up output pins, so a disabled pin reads high.
*/
`timescale 1ns/1ps
`default_nettype none

module sys_logic_model
  import seq_pkg::*;
(
  input  wire logic [N_EXT-1:0] ext_drive_i,
  input  wire logic [N_OUT-1:0] fb_sel_i,
  input  wire logic [N_OUT-1:0] output_bit_i,
  input  wire logic             output_bit_oe_i,
  output logic      [N_EXT-1:0] ext_input_o
);
  logic [N_OUT-1:0] pin_level;

  ////////////////////////////////////////////////////////////////////////////////
  // a released pin floats to the pull-up, never the last driven value
  assign pin_level = output_bit_oe_i ? output_bit_i : {N_OUT{1'b1}};

  // selected pins replace the upper inputs, widening the state register
  assign ext_input_o[N_EXT-1:N_OUT] = (fb_sel_i & pin_level)
                                    | (~fb_sel_i & ext_drive_i[N_EXT-1:N_OUT]);
  assign ext_input_o[N_OUT-1:0]     = ext_drive_i[N_OUT-1:0];
endmodule

`default_nettype wire

// [dv/mealy_sequencer_bench.sv]
/*
  Self-checking bench of the Mealy sequencer: loads a small transition
  pattern, walks direct and complement jumps, preset, output enable
  and store writes. Assumes seq_pkg and the design files compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module mealy_sequencer_bench
  import seq_pkg::*;
;
  logic                  clk            = 1'b0;
  logic                  rst_n          = 1'b0;
  logic [N_EXT-1:0]      ext_drive      = 16'h0000;
  logic [N_OUT-1:0]      fb_sel         = 8'h80;
  logic [N_EXT-1:0]      ext_in;
  logic                  pin            = 1'b0;
  logic                  cfg_we         = 1'b0;
  logic [TERM_IDX_W-1:0] cfg_term       = 6'h00;
  logic [CFG_W-1:0]      cfg_word       = '0;
  logic                  cfg_opt_we     = 1'b0;
  logic                  cfg_opt_preset = 1'b1;
  logic [N_OUT-1:0]      out_bits;
  logic                  oe;
  logic [N_STATE-1:0]    state;
  logic [CFG_W-1:0]      words [7];
  int                    error_cnt      = 0;
  int                    compares       = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // clock, partner and design
  always #5 clk = ~clk;

  sys_logic_model i_sys (
    .ext_drive_i     (ext_drive),
    .fb_sel_i        (fb_sel),
    .output_bit_i    (out_bits),
    .output_bit_oe_i (oe),
    .ext_input_o     (ext_in)
  );

  mealy_sequencer i_dut (
    .clk_i                         (clk),
    .rst_n_i                       (rst_n),
    .ext_input_i                   (ext_in),
    .preset_or_output_enable_pin_i (pin),
    .cfg_we_i                      (cfg_we),
    .cfg_term_i                    (cfg_term),
    .cfg_word_i                    (cfg_word),
    .cfg_opt_we_i                  (cfg_opt_we),
    .cfg_opt_preset_i              (cfg_opt_preset),
    .output_bit_o                  (out_bits),
    .output_bit_oe_o               (oe),
    .present_state_bit_o           (state)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // one term word; never set and reset together, never generate and propagate
  function automatic logic [CFG_W-1:0] mk(input logic [5:0] s, input logic [15:0] e1, e0,
                                          input logic gen, prop, input logic [13:0] set, clr);
    mk = {clr, set, prop, gen, e0, ~s, e1, s};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regs(input logic [5:0] s, input logic [7:0] o);
    chk({10'h000, state}, {10'h000, s});
    chk({8'h00, out_bits}, {8'h00, o});
  endtask

  // tick and opt start and end at a falling edge
  task automatic tick(input logic [15:0] e);
    ext_drive = e;
    @(negedge clk);
  endtask

  task automatic opt(input logic v);
    cfg_opt_we = 1'b1;
    cfg_opt_preset = v;
    @(negedge clk);
    cfg_opt_we = 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s finished, mismatches so far %0d", n, error_cnt);
  endtask

  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    words[0] = mk(6'h3f, 16'h0001, 16'h0000, 1'b0, 1'b0, 14'h0000, {8'hf0, 6'h3f});
    words[1] = mk(6'h00, 16'h0002, 16'h0000, 1'b0, 1'b0, {8'h00, 6'h01}, 14'h0000);
    words[2] = mk(6'h01, 16'h0004, 16'h0004, 1'b0, 1'b0, {8'h00, 6'h02}, 14'h0000);
    words[3] = mk(6'h01, 16'h0008, 16'h0000, 1'b1, 1'b0, {8'h80, 6'h00}, 14'h0000);
    words[4] = mk(6'h01, 16'h0000, 16'h0000, 1'b0, 1'b1, {8'h40, 6'h04}, 14'h0000);
    words[5] = mk(6'h05, 16'h0000, 16'h0000, 1'b0, 1'b1, {8'h00, 6'h08}, 14'h0000);
    words[6] = mk(6'h0d, 16'h8000, 16'h0000, 1'b0, 1'b0, {8'h00, 6'h10}, {8'h80, 6'h00});
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    regs(6'h3f, 8'hff);
    chk({15'h0000, oe}, 16'h0001);
    tick(16'hffff);
    tick(16'h0000);
    regs(6'h3f, 8'hff);
    done("virgin");
    // load the pattern; we held high across all words, regs frozen
    cfg_we = 1'b1;
    for (int i = 0; i < 7; i++) begin
      cfg_term = 6'(i);
      cfg_word = words[i];
      @(negedge clk);
    end
    cfg_we = 1'b0;
    tick(16'h0000);
    regs(6'h3f, 8'hff);
    ext_drive = 16'h0001;
    #1;
    chk({10'h000, state}, 16'h003f);
    @(negedge clk);
    regs(6'h00, 8'h0f);
    tick(16'h0002);
    regs(6'h01, 8'h0f);
    tick(16'h000c);
    tick(16'h0008);
    regs(6'h01, 8'h8f);
    tick(16'h0000);
    regs(6'h05, 8'hcf);
    tick(16'h0008);
    regs(6'h0d, 8'hcf);
    tick(16'h0000);
    regs(6'h1d, 8'h4f);
    done("jumps");
    // preset is the default option: async ones, clocking inhibited
    pin = 1'b1;
    #1;
    regs(6'h3f, 8'hff);
    ext_drive = 16'h0001;
    repeat (2) @(negedge clk);
    regs(6'h3f, 8'hff);
    pin = 1'b0;
    @(negedge clk);
    regs(6'h00, 8'h0f);
    done("preset");
    // output enable option: pin no longer presets
    opt(1'b0);
    pin = 1'b1;
    @(negedge clk);
    chk({15'h0000, oe}, 16'h0000);
    regs(6'h00, 8'h0f);
    pin = 1'b0;
    @(negedge clk);
    chk({15'h0000, oe}, 16'h0001);
    done("enable");
    // write to a term index past the array: ignored, edge still frozen
    ext_drive = 16'h0002;
    cfg_we = 1'b1;
    cfg_term = 6'h32;
    cfg_word = mk(6'h00, 16'h0000, 16'h0000, 1'b0, 1'b0, {8'hff, 6'h00}, 14'h0000);
    @(negedge clk);
    cfg_we = 1'b0;
    regs(6'h00, 8'h0f);
    tick(16'h0002);
    regs(6'h01, 8'h0f);
    done("store");
    give_verdict();
  end
endmodule

`default_nettype wire
